// File: timer_modules_core.v
/*
 Seven timer modules (three standard, four periodic) with a common
 byte register port, pin synchronisers and sticky compare flags.
 Assumes the register master obeys the one-cycle strobe protocol and
 that the internal high clock equals core_clk.
*/
// Notes on behaviour
// - Seven modules: three standard, four periodic
// - Free-running up counter compared for equality
// - Match flags, may clear counter, drive pin
// - Separate A and P flags per module
// - Three-bit field selects counter clock source
// - External pin counts rising or falling edges
// - Clock pin triggers single pulse mode
// - Capture edge rising, falling or both
// - Periodic capture may use clock pin
// - Compare match sets, clears or toggles pin
// - PWM appears on the same output pin
// - High bytes direct, low bytes via buffer
// - Low write buffers, high write commits both
// - High read latches low into buffer
// - Standard clock select code mapping
// - Switch on clears counter, off holds; single pulse trigger still clears
// - Standard P compares top eight bits
`timescale 1ns/10ps
`default_nettype none
`include "timer_core_consts.vh"

module timer_modules_core (
	input  wire       core_clk,
	input  wire       reset_n,
	input  wire [5:0] bus_addr,
	input  wire [7:0] bus_wdata,
	input  wire       bus_wr,
	input  wire       bus_rd,
	output reg  [7:0] bus_rdata_ff,
	input  wire [2:0] std_ext_clock_pin,
	input  wire [3:0] per_ext_clock_pin,
	input  wire [2:0] std_capture_pin,
	input  wire [3:0] per_capture_pin,
	input  wire       subsystem_clock,
	output wire [6:0] timer_output_pin,
	output wire [6:0] irq_a,
	output wire [6:0] irq_p
);

	reg  [`PRESC_W-1:0] presc_ff;
	wire [6:0]          clk_rise;
	wire [6:0]          clk_fall;
	wire [6:0]          cap_rise;
	wire [6:0]          cap_fall;
	wire                sub_rise;
	wire                sub_fall;
	wire [6:0]          fa_vec;
	wire [6:0]          fp_vec;
	wire [55:0]         rd_bus;
	wire [2:0]          blk;
	wire [2:0]          ofs;
	wire                status_wr;
	reg  [7:0]          nxt_rdata;

	assign blk = bus_addr[5:3];
	assign ofs = bus_addr[2:0];
	assign status_wr = bus_wr & (blk == `STATUS_BLOCK);

	// Clock select decode shared by all modules
	function count_tick;
		input [2:0]          sel;
		input [`PRESC_W-1:0] pv;
		input                sub_r;
		input                ext_r;
		input                ext_f;
		begin
			case (sel)
			`CKS_SYS4:  count_tick = (pv & `DIV4_MASK) == `DIV4_MASK;
			`CKS_SYS:   count_tick = 1'b1;
			`CKS_H16:   count_tick = (pv & `DIV16_MASK) == `DIV16_MASK;
			`CKS_H64:   count_tick = pv == `DIV64_MASK;
			`CKS_SUB_A: count_tick = sub_r;
			`CKS_SUB_B: count_tick = sub_r;
			`CKS_EXT_R: count_tick = ext_r;
			default:    count_tick = ext_f;
			endcase
		end
	endfunction

	// Period comparator; a zero period matches at counter overflow
	function p_hit;
		input [15:0] cnt;
		input [15:0] pv;
		begin
			if (pv == `RST_WORD)
				p_hit = cnt == `CNT_TOP;
			else
				p_hit = cnt == pv;
		end
	endfunction

	// Capture trigger by edge select
	function cap_hit;
		input       is_per;
		input [1:0] io;
		input       r;
		input       f;
		input       alt_r;
		begin
			case (io)
			`EDGE_RISE: cap_hit = r;
			`EDGE_FALL: cap_hit = f;
			`EDGE_BOTH: cap_hit = r | f;
			default:    cap_hit = is_per & alt_r;
			endcase
		end
	endfunction

	// All pins pass two flops before edge detection
	pin_sync_edge #(
		.WIDTH (15)
	) u_pin_sync (
		.clk      (core_clk),
		.reset_n  (reset_n),
		.async_in ({subsystem_clock, per_capture_pin, std_capture_pin,
		            per_ext_clock_pin, std_ext_clock_pin}),
		.rise_ff  ({sub_rise, cap_rise, clk_rise}),
		.fall_ff  ({sub_fall, cap_fall, clk_fall})
	);

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			presc_ff <= {`PRESC_W{1'b0}};
		else
			presc_ff <= presc_ff + {{(`PRESC_W-1){1'b0}}, 1'b1};
	end

	genvar i;
	generate
	for (i = 0; i < `NUM_TIMERS; i = i + 1) begin : g_tm
		localparam       IS_PER = (i >= `NUM_STD) ? 1'b1 : 1'b0;
		localparam [31:0] IDX   = i;
		reg  [7:0]  ctl0_ff;
		reg  [7:0]  ctl1_ff;
		reg  [7:0]  buf_ff;
		reg  [7:0]  a_hi_ff;
		reg  [7:0]  a_lo_ff;
		reg  [7:0]  p_hi_ff;
		reg  [7:0]  p_lo_ff;
		reg  [15:0] cnt_ff;
		reg         on_d_ff;
		reg         out_ff;
		reg         pin_ff;
		reg         fa_ff;
		reg         fp_ff;
		reg         nxt_out;
		reg  [7:0]  rd_byte;
		wire        wr_me;
		wire        rd_me;
		wire        running;
		wire        on_rise;
		wire        tick;
		wire [15:0] a_val;
		wire [15:0] p_val;
		wire [15:0] duty;
		wire        hit_a;
		wire        hit_p;
		wire [1:0]  mode;
		wire [1:0]  io;
		wire        oc;
		wire        single;
		wire        trig;
		wire        cap_ev;
		wire        clr;
		wire        set_a;

		assign wr_me   = bus_wr & (blk == IDX[2:0]);
		assign rd_me   = bus_rd & (blk == IDX[2:0]);
		assign mode    = ctl1_ff[`C1_MODE_HI:`C1_MODE_LO];
		assign io      = ctl1_ff[`C1_IO_HI:`C1_IO_LO];
		assign oc      = ctl1_ff[`C1_OC];
		assign running = ctl0_ff[`C0_ON] & ~ctl0_ff[`C0_PAUSE];
		assign on_rise = ctl0_ff[`C0_ON] & ~on_d_ff;
		assign tick    = running & count_tick(ctl0_ff[`C0_CKS_HI:`C0_CKS_LO],
		                 presc_ff, sub_rise, clk_rise[i], clk_fall[i]);
		assign a_val   = {a_hi_ff, a_lo_ff};
		// Standard P low byte is never written, so only the top 8 bits count
		assign p_val   = {p_hi_ff, p_lo_ff};
		assign hit_a   = tick & (cnt_ff == a_val);
		assign hit_p   = tick & p_hit(cnt_ff, p_val);
		assign single  = (mode == `MODE_PWM) & (io == `EDGE_ALT);
		assign trig    = single & clk_rise[i];
		assign cap_ev  = (mode == `MODE_CAP) &
		                 cap_hit(IS_PER, io, cap_rise[i], cap_fall[i],
		                 clk_rise[i]);
		assign duty    = ctl1_ff[`C1_DPX] ? p_val : a_val;
		assign clr     = (mode == `MODE_PWM) ?
		                 (ctl1_ff[`C1_DPX] ? hit_a : hit_p) :
		                 (mode == `MODE_CAP) ? hit_p :
		                 (ctl1_ff[`C1_CCLR] ? hit_a : hit_p);
		assign set_a   = hit_a | cap_ev;

		// Register writes and the shared low-byte buffer
		always @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				ctl0_ff <= `RST_BYTE;
				ctl1_ff <= `RST_BYTE;
				buf_ff  <= `RST_BYTE;
				a_hi_ff <= `RST_BYTE;
				a_lo_ff <= `RST_BYTE;
				p_hi_ff <= `RST_BYTE;
				p_lo_ff <= `RST_BYTE;
			end else begin
				if (wr_me) begin
					case (ofs)
					`OFS_CTL0: ctl0_ff <= bus_wdata & `C0_MASK;
					`OFS_CTL1: ctl1_ff <= bus_wdata;
					`OFS_A_LO: buf_ff <= bus_wdata;
					`OFS_A_HI: begin
						a_hi_ff <= bus_wdata;
						a_lo_ff <= buf_ff;
					end
					`OFS_P_LO: begin
						if (IS_PER)
							buf_ff <= bus_wdata;
						else
							p_hi_ff <= bus_wdata;
					end
					`OFS_P_HI: begin
						if (IS_PER) begin
							p_hi_ff <= bus_wdata;
							p_lo_ff <= buf_ff;
						end
					end
					default: ;
					endcase
				end else if (rd_me) begin
					case (ofs)
					`OFS_CNT_HI: buf_ff <= cnt_ff[7:0];
					`OFS_A_HI:   buf_ff <= a_lo_ff;
					`OFS_P_HI: begin
						if (IS_PER)
							buf_ff <= p_lo_ff;
					end
					default: ;
					endcase
				end
				// A capture overrides a same-cycle software write
				if (cap_ev) begin
					a_hi_ff <= cnt_ff[15:8];
					a_lo_ff <= cnt_ff[7:0];
				end
			end
		end

		// Counter: switch-on clears; switch-off and pause hold, but a single-pulse trigger still clears
		always @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				cnt_ff  <= `RST_WORD;
				on_d_ff <= 1'b0;
			end else begin
				on_d_ff <= ctl0_ff[`C0_ON];
				if (on_rise | trig)
					cnt_ff <= `RST_WORD;
				else if (tick)
					cnt_ff <= clr ? `RST_WORD : cnt_ff + 16'h0001;
			end
		end

		// Output level by mode
		always @* begin
			nxt_out = out_ff;
			case (mode)
			`MODE_CMP: begin
				if (on_rise)
					nxt_out = oc;
				else if (hit_a) begin
					case (io)
					`IO_LOW:    nxt_out = 1'b0;
					`IO_HIGH:   nxt_out = 1'b1;
					`IO_TOGGLE: nxt_out = ~out_ff;
					default:    nxt_out = out_ff;
					endcase
				end
			end
			`MODE_PWM: begin
				if (single) begin
					if (trig)
						nxt_out = oc;
					else if (hit_a)
						nxt_out = ~oc;
				end else if (!ctl0_ff[`C0_ON])
					nxt_out = ~oc;
				else
					nxt_out = (cnt_ff < duty) ? oc : ~oc;
			end
			default: nxt_out = out_ff;
			endcase
		end

		// Flags: a set in the clear cycle wins
		always @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				out_ff <= 1'b0;
				pin_ff <= 1'b0;
				fa_ff  <= 1'b0;
				fp_ff  <= 1'b0;
			end else begin
				out_ff <= nxt_out;
				pin_ff <= nxt_out ^ ctl1_ff[`C1_POL];
				fa_ff  <= set_a | (fa_ff & ~(status_wr &
				          (ofs == `OFS_FLAG_A) & bus_wdata[i]));
				fp_ff  <= hit_p | (fp_ff & ~(status_wr &
				          (ofs == `OFS_FLAG_P) & bus_wdata[i]));
			end
		end

		always @* begin
			rd_byte = `RST_BYTE;
			case (ofs)
			`OFS_CTL0:   rd_byte = ctl0_ff;
			`OFS_CTL1:   rd_byte = ctl1_ff;
			`OFS_CNT_LO: rd_byte = buf_ff;
			`OFS_CNT_HI: rd_byte = cnt_ff[15:8];
			`OFS_A_LO:   rd_byte = buf_ff;
			`OFS_A_HI:   rd_byte = a_hi_ff;
			`OFS_P_LO:   rd_byte = IS_PER ? buf_ff : p_hi_ff;
			`OFS_P_HI:   rd_byte = IS_PER ? p_hi_ff : `RST_BYTE;
			default:     rd_byte = `RST_BYTE;
			endcase
		end

		assign rd_bus[8*i +: 8]    = rd_byte;
		assign timer_output_pin[i] = pin_ff;
		assign fa_vec[i]           = fa_ff;
		assign fp_vec[i]           = fp_ff;
	end
	endgenerate

	assign irq_a = fa_vec;
	assign irq_p = fp_vec;

	always @* begin
		nxt_rdata = `RST_BYTE;
		if (bus_rd) begin
			if (blk == `STATUS_BLOCK) begin
				if (ofs == `OFS_FLAG_A)
					nxt_rdata = {1'b0, fa_vec};
				else if (ofs == `OFS_FLAG_P)
					nxt_rdata = {1'b0, fp_vec};
			end else
				nxt_rdata = rd_bus[{blk, 3'b000} +: 8];
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			bus_rdata_ff <= `RST_BYTE;
		else
			bus_rdata_ff <= nxt_rdata;
	end

endmodule

`default_nettype wire

// File: timer_core_consts.vh
/*
 Constants for the seven-module timer core: register offsets, control
 field positions, mode and select codes, reset values.
 Assumes inclusion by bare name from the timer core design files.
*/
`ifndef TIMER_CORE_CONSTS_VH
`define TIMER_CORE_CONSTS_VH

`define NUM_TIMERS    7
`define NUM_STD       3
`define PRESC_W       6

// Address split: bits 5:3 pick the module, bits 2:0 the register
`define OFS_CTL0      3'h0
`define OFS_CTL1      3'h1
`define OFS_CNT_LO    3'h2
`define OFS_CNT_HI    3'h3
`define OFS_A_LO      3'h4
`define OFS_A_HI      3'h5
`define OFS_P_LO      3'h6
`define OFS_P_HI      3'h7
`define STATUS_BLOCK  3'h7
`define OFS_FLAG_A    3'h0
`define OFS_FLAG_P    3'h1

`define C0_PAUSE      7
`define C0_CKS_HI     6
`define C0_CKS_LO     4
`define C0_ON         3
`define C0_MASK       8'hF8
`define C1_MODE_HI    7
`define C1_MODE_LO    6
`define C1_IO_HI      5
`define C1_IO_LO      4
`define C1_OC         3
`define C1_POL        2
`define C1_DPX        1
`define C1_CCLR       0

`define MODE_CMP      2'h0
`define MODE_CAP      2'h1
`define MODE_PWM      2'h2
`define MODE_TMR      2'h3

`define IO_NONE       2'h0
`define IO_LOW        2'h1
`define IO_HIGH       2'h2
`define IO_TOGGLE     2'h3
`define EDGE_RISE     2'h0
`define EDGE_FALL     2'h1
`define EDGE_BOTH     2'h2
`define EDGE_ALT      2'h3

`define CKS_SYS4      3'h0
`define CKS_SYS       3'h1
`define CKS_H16       3'h2
`define CKS_H64       3'h3
`define CKS_SUB_A     3'h4
`define CKS_SUB_B     3'h5
`define CKS_EXT_R     3'h6
`define CKS_EXT_F     3'h7

`define DIV4_MASK     6'h03
`define DIV16_MASK    6'h0F
`define DIV64_MASK    6'h3F

`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
`define CNT_TOP       16'hFFFF

`endif

// File: pin_sync_edge.v
/*
 Two-stage synchroniser with registered edge pulses for a group of pins.
 Assumes inputs are asynchronous to clk and change slower than clk.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_sync_edge #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] rise_ff,
	output reg  [WIDTH-1:0] fall_ff
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	reg [WIDTH-1:0] last_ff;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
			last_ff <= {WIDTH{1'b0}};
			rise_ff <= {WIDTH{1'b0}};
			fall_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
			rise_ff <= sync_ff & ~last_ff;
			fall_ff <= ~sync_ff & last_ff;
		end
	end

endmodule

`default_nettype wire

// File: timer_pin_partner.sv
/*
 Board-side model: drives the timer clock, capture and subsystem pins.
 Assumes pins are sampled asynchronously by the timer core.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_pin_partner (
	output wire logic [2:0] std_ext_clock_pin,
	output wire logic [3:0] per_ext_clock_pin,
	output wire logic [2:0] std_capture_pin,
	output wire logic [3:0] per_capture_pin,
	output var  logic       subsystem_clock
);
	logic [6:0] ext_lv = 7'h00;
	logic [6:0] cap_lv = 7'h00;
	assign {per_ext_clock_pin, std_ext_clock_pin} = ext_lv;
	assign {per_capture_pin, std_capture_pin} = cap_lv;
	initial subsystem_clock = 1'b0;
	// Free-running, unrelated in phase to the core clock
	always #47 subsystem_clock = ~subsystem_clock;
	// Pins move off the core clock edges
	task set_pin(input int idx, input bit cap, input bit lvl);
		#3;
		if (cap)
			cap_lv[idx] = lvl;
		else
			ext_lv[idx] = lvl;
	endtask
	// Each level held four core cycles so every edge is seen once
	task pulse(input int idx, input int n);
		repeat (n) begin
			set_pin(idx, 1'b0, 1'b1);
			#40;
			set_pin(idx, 1'b0, 1'b0);
			#40;
		end
	endtask
endmodule
`default_nettype wire

// File: timer_modules_core_monitor.sv
/*
 Checker for the timer core register port and sticky flags.
 Assumes it is bound to timer_modules_core.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_core_checker (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic [5:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata_ff,
	input wire logic [6:0] timer_output_pin,
	input wire logic [6:0] irq_a,
	input wire logic [6:0] irq_p
);
	logic [6:0] keep_a_ff;
	logic [6:0] keep_p_ff;
	wire        clr_a = bus_wr && bus_addr == 6'h38;
	wire        clr_p = bus_wr && bus_addr == 6'h39;
	// Flags that were set and not cleared must still be set
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			keep_a_ff <= 7'h00;
			keep_p_ff <= 7'h00;
		end else begin
			keep_a_ff <= irq_a & ~(clr_a ? bus_wdata[6:0] : 7'h00);
			keep_p_ff <= irq_p & ~(clr_p ? bus_wdata[6:0] : 7'h00);
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence pair_wr;
		bus_wr && bus_addr == 6'h04 ##1 bus_wr && bus_addr == 6'h05;
	endsequence
	chk_rdata_idle: assert property (!bus_rd |=> bus_rdata_ff == 8'h00)
		else $error("read data not zero outside a read");
	chk_flag_a_keep: assert property ((keep_a_ff & ~irq_a) == 7'h00)
		else $error("flag A dropped without a clear");
	chk_flag_p_keep: assert property ((keep_p_ff & ~irq_p) == 7'h00)
		else $error("flag P dropped without a clear");
	chk_status_read: assert property (bus_rd && bus_addr == 6'h38 |=>
		bus_rdata_ff == {1'b0, $past(irq_a)})
		else $error("status read differs from flags");
	chk_unmapped_zero: assert property (bus_rd && bus_addr[5:3] == 3'h7 &&
		bus_addr[2:1] != 2'h0 |=> bus_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	chk_ctl0_back: assert property (bus_wr && bus_addr[2:0] == 3'h0 &&
		bus_addr[5:3] != 3'h7 ##1 bus_rd && $stable(bus_addr) |=>
		bus_rdata_ff == ($past(bus_wdata, 2) & 8'hF8))
		else $error("control read back wrong");
	chk_pair_high: assert property (pair_wr ##1 bus_rd && bus_addr == 6'h05
		|=> bus_rdata_ff == $past(bus_wdata, 2))
		else $error("high byte read back wrong");
	chk_pair_low: assert property (pair_wr ##1 bus_rd && bus_addr == 6'h05
		##1 bus_rd && bus_addr == 6'h04 |=> bus_rdata_ff == $past(bus_wdata, 4))
		else $error("low byte read back wrong");
	cover property ($rose(irq_a[0]));
	cover property ($rose(irq_p[2]));
	cover property ($changed(timer_output_pin[0]));
	cover property ($rose(timer_output_pin[6]));
endmodule
bind timer_modules_core timer_core_checker u_timer_core_checker (.core_clk,
	.reset_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_ff,
	.timer_output_pin, .irq_a, .irq_p);
`default_nettype wire

// File: timer_modules_core_tb.sv
/*
 Self-checking bench for the seven-module timer core.
 Assumes the pin partner model and the bound checker are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_modules_core_tb;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [5:0]  bus_addr = 6'h00;
	logic [7:0]  bus_wdata = 8'h00;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	wire  [7:0]  bus_rdata_ff;
	wire  [2:0]  std_ext_clock_pin;
	wire  [3:0]  per_ext_clock_pin;
	wire  [2:0]  std_capture_pin;
	wire  [3:0]  per_capture_pin;
	wire         subsystem_clock;
	wire  [6:0]  timer_output_pin;
	wire  [6:0]  irq_a;
	wire  [6:0]  irq_p;
	logic [7:0]  exp_q[$];
	logic        rd_d = 1'b0;
	logic [5:0]  lo_a[3] = '{6'h04, 6'h1C, 6'h2E};
	logic [15:0] val;
	int          err_count = 0;
	int          checked = 0;
	int          e;
	always #5 core_clk = ~core_clk;
	timer_modules_core u_timer_modules_core (.core_clk, .reset_n, .bus_addr,
		.bus_wdata, .bus_wr, .bus_rd, .bus_rdata_ff, .std_ext_clock_pin,
		.per_ext_clock_pin, .std_capture_pin, .per_capture_pin,
		.subsystem_clock, .timer_output_pin, .irq_a, .irq_p);
	timer_pin_partner u_timer_pin_partner (.std_ext_clock_pin,
		.per_ext_clock_pin, .std_capture_pin, .per_capture_pin,
		.subsystem_clock);
	task bad(input string msg);
		err_count++;
		$display("BAD %0t %s", $time, msg);
	endtask
	task final_report;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One bus cycle; for a read, d is the expected data
	task bus(input logic w, input logic r, input logic [5:0] a,
		input logic [7:0] d);
		bus_wr <= w;
		bus_rd <= r;
		bus_addr <= a;
		bus_wdata <= d;
		if (r)
			exp_q.push_back(d);
		@(posedge core_clk);
	endtask
	task wait_irq(input int m, input bit p, input logic x, input int n);
		int i;
		for (i = 0; i < n && (p ? irq_p[m] : irq_a[m]) !== 1'b1; i++)
			@(posedge core_clk);
		checked++;
		if ((p ? irq_p[m] : irq_a[m]) !== x) begin
			bad("flag level wrong");
			if (x)
				final_report;
		end
	endtask
	// Counts the cycles in n in which output pin m stands high
	task count_high(input int m, input int n, input int x);
		int k;
		int hi;
		hi = 0;
		for (k = 0; k < n; k++) begin
			@(posedge core_clk);
			hi += timer_output_pin[m];
		end
		checked++;
		if (hi != x)
			bad("output high count wrong");
	endtask
	always @(posedge core_clk) begin
		if (rd_d) begin
			checked++;
			if (exp_q.size() == 0)
				bad("read with no note");
			else if (bus_rdata_ff !== exp_q.pop_front())
				bad("read data mismatch");
		end
		rd_d <= bus_rd;
	end
	initial begin
		#900000;
		bad("run timed out");
		final_report;
	end
	initial begin
		e = $urandom(37);
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		bus(0, 1, 6'h00, 8'h00);
		bus(0, 1, 6'h21, 8'h00);
		bus(0, 1, 6'h38, 8'h00);
		for (e = 0; e < 3; e++) begin
			val = 16'($urandom);
			bus(1, 0, lo_a[e], val[7:0]);
			bus(1, 0, lo_a[e] + 6'h01, val[15:8]);
			bus(0, 1, lo_a[e] + 6'h01, val[15:8]);
			bus(0, 1, lo_a[e], val[7:0]);
		end
		bus(1, 0, 6'h0E, 8'hA5);
		bus(0, 1, 6'h0E, 8'hA5);
		bus(1, 0, 6'h0B, 8'h55);
		bus(0, 1, 6'h0B, 8'h00);
		bus(0, 1, 6'h3A, 8'h00);
		bus(1, 0, 6'h04, 8'h04);
		bus(1, 0, 6'h05, 8'h00);
		bus(1, 0, 6'h01, 8'h31);
		bus(1, 0, 6'h00, 8'h18);
		bus(0, 1, 6'h00, 8'h18);
		bus(0, 0, 6'h00, 8'h00);
		wait_irq(0, 0, 1'b1, 20);
		repeat (2) @(posedge core_clk);
		checked++;
		if (timer_output_pin[0] !== 1'b1)
			bad("output pin did not toggle");
		bus(1, 0, 6'h00, 8'h00);
		bus(0, 0, 6'h00, 8'h00);
		bus(0, 1, 6'h38, 8'h01);
		bus(1, 0, 6'h38, 8'h01);
		bus(0, 1, 6'h38, 8'h00);
		bus(1, 0, 6'h16, 8'h01);
		bus(1, 0, 6'h10, 8'h18);
		bus(0, 0, 6'h00, 8'h00);
		wait_irq(2, 1, 1'b1, 300);
		bus(1, 0, 6'h19, 8'hC0);
		for (e = 6; e < 8; e++) begin
			bus(1, 0, 6'h18, 8'h00);
			bus(1, 0, 6'h18, {1'b0, 3'(e), 4'h8});
			bus(0, 0, 6'h00, 8'h00);
			u_timer_pin_partner.pulse(3, 4);
			repeat (6) @(posedge core_clk);
			bus(0, 1, 6'h1B, 8'h00);
			bus(0, 1, 6'h1A, 8'h04);
			bus(0, 0, 6'h00, 8'h00);
		end
		for (e = 0; e < 3; e++) begin
			bus(1, 0, 6'h09, {2'h1, 2'(e), 4'h0});
			bus(1, 0, 6'h08, 8'h18);
			// Let the counter leave zero so its A match cannot mask the clear
			bus(0, 0, 6'h00, 8'h00);
			bus(0, 0, 6'h00, 8'h00);
			bus(1, 0, 6'h38, 8'h02);
			bus(0, 0, 6'h00, 8'h00);
			u_timer_pin_partner.set_pin(1, 1'b1, 1'b1);
			wait_irq(1, 0, e != 1, 12);
			bus(1, 0, 6'h38, 8'h02);
			bus(0, 0, 6'h00, 8'h00);
			u_timer_pin_partner.set_pin(1, 1'b1, 1'b0);
			wait_irq(1, 0, e != 0, 12);
		end
		// Periodic capture from the clock pin
		bus(1, 0, 6'h21, 8'h70);
		bus(1, 0, 6'h20, 8'h18);
		bus(0, 0, 6'h00, 8'h00);
		bus(0, 0, 6'h00, 8'h00);
		bus(1, 0, 6'h38, 8'h10);
		bus(0, 0, 6'h00, 8'h00);
		u_timer_pin_partner.set_pin(4, 1'b0, 1'b1);
		wait_irq(4, 0, 1'b1, 12);
		// PWM: period 10 counts, duty 4, initial level high
		bus(1, 0, 6'h34, 8'h04);
		bus(1, 0, 6'h35, 8'h00);
		bus(1, 0, 6'h36, 8'h09);
		bus(1, 0, 6'h37, 8'h00);
		bus(1, 0, 6'h31, 8'h88);
		bus(1, 0, 6'h30, 8'h18);
		bus(0, 0, 6'h00, 8'h00);
		repeat (12) @(posedge core_clk);
		count_high(6, 20, 8);
		// Single pulse: trigger on clock pin, ends on A match at 6
		bus(1, 0, 6'h2C, 8'h06);
		bus(1, 0, 6'h2D, 8'h00);
		bus(1, 0, 6'h2E, 8'h00);
		bus(1, 0, 6'h2F, 8'h00);
		bus(1, 0, 6'h29, 8'hB8);
		bus(1, 0, 6'h28, 8'h18);
		bus(0, 0, 6'h00, 8'h00);
		u_timer_pin_partner.set_pin(5, 1'b0, 1'b1);
		count_high(5, 20, 7);
		repeat (4) @(posedge core_clk);
		final_report;
	end
endmodule
`default_nettype wire
